// >>> tb/sslind_switch_model.sv
`timescale 1ns/1ps
// Operator reset switch: a dry contact closed for a set time on request
module sslind_switch_model (
  input  wire logic       mclk,         // Clock
  input  wire logic       go,           // Start a closure
  input  wire logic [7:0] holdCyc,      // Closure length in cycles
  output logic            resetClosed = 1'b0,  // Contact, high = closed
  output logic            busy = 1'b0          // Closure in progress
);
  logic [7:0] cnt = 8'h0;

  // Contact opens again after exactly holdCyc cycles; bench picks legal or bad lengths
  always @(posedge mclk) begin
    if (go && !busy) begin
      resetClosed <= 1'b1;
      busy <= 1'b1;
      cnt <= holdCyc;
    end else if (busy) begin
      cnt <= cnt - 8'h1;
      if (cnt == 8'h1) begin
        resetClosed <= 1'b0; // Open contact reads low
        busy <= 1'b0;
      end
    end
  end
endmodule // sslind_switch_model

// >>> tb/sslind_top_asserts.sv
`timescale 1ns/1ps
// Port-level checks on the status and lockout block
module sslind_top_asserts
  import sslind_pkg::*;
#(
  parameter int unsigned NUM_CIRC = 4
) (
  input wire logic                mclk,             // Clock
  input wire logic                rst_b,            // Reset, active low
  input wire logic [NUM_CIRC-1:0] circActive,       // Circuit levels
  input wire logic [1:0]          timerSel,         // Timer setting
  input wire logic                muteActive,       // Mute in progress
  input wire logic                faultPresent,     // Fault level
  input wire sslind_lamps_t       lamps,            // Status lamps
  input wire sslind_display_t     display,          // Display
  input wire logic [NUM_CIRC-1:0] circGreen,        // Circuit green
  input wire logic [NUM_CIRC-1:0] circYellow,       // Circuit yellow
  input wire logic [1:0]          safetyOutputPair  // Safety outputs
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  // A split pair would leave one channel driving the machine
  pair_match_a: assert property (safetyOutputPair[0] == safetyOutputPair[1])
    else $error("safety outputs disagree");
  fault_stop_a: assert property ($rose(faultPresent) |-> ##[1:3] safetyOutputPair == 2'h0)
    else $error("outputs not off after fault");
  fault_hold_a: assert property (faultPresent [*3] |-> !lamps.green && safetyOutputPair == 2'h0)
    else $error("left lockout while fault present");
  dark_code_a: assert property (lamps == 3'h0 |-> display.mode == DISP_NUMBER)
    else $error("lockout without error code");
  green_yel_a: assert property (lamps.green |-> !lamps.yellow)
    else $error("green and yellow together");
  on_green_a: assert property (safetyOutputPair == 2'h3 |-> lamps.green)
    else $error("outputs on without green");
  circ_follow_a: assert property (circGreen == $past(circActive, 3) && circYellow == circGreen)
    else $error("circuit lamps do not follow");
  dash_idle_a: assert property ((!muteActive && !faultPresent && lamps.green) [*3]
    |-> display.mode == DISP_DASH)
    else $error("no steady dash when idle");
  timer_num_a: assert property ((muteActive && timerSel != TLIM_OFF && lamps.green) [*3]
    |-> display.mode == DISP_NUMBER && display.value <= 7'h3c)
    else $error("timer count not shown");
  timer_off_a: assert property ((muteActive && timerSel == TLIM_OFF && lamps.green) [*3]
    |-> display.mode != DISP_NUMBER)
    else $error("number shown with timer off");

  // Main scenarios reached
  cover property (lamps == 3'h0);
  cover property ($rose(safetyOutputPair == 2'h3));
  cover property (display.mode == DISP_NUMBER && display.value == ERR_RESET_INPUT);
endmodule // sslind_top_asserts

bind sslind_top sslind_top_asserts #(.NUM_CIRC(NUM_CIRC)) i_chk (
  .mclk, .rst_b, .circActive, .timerSel, .muteActive, .faultPresent,
  .lamps, .display, .circGreen, .circYellow, .safetyOutputPair
);

// >>> tb/tb.sv
`timescale 1ns/1ps
module tb;
  import sslind_pkg::*;
  localparam int unsigned FC = 4;
  localparam int unsigned SC = 8;
  logic            mclk = 1'b0;
  logic            rst_b = 1'b0;
  logic            swGo = 1'b0;
  logic [7:0]      swHold = 8'h0;
  logic            resetClosed;
  logic            swBusy;
  logic [3:0]      circActive = 4'h0;
  logic [1:0]      timerSel = 2'h0;
  logic            runReq = 1'b0;
  logic            overrideReq = 1'b0;
  logic            muteActive = 1'b0;
  logic            faultPresent = 1'b0;
  logic [6:0]      faultCode = 7'h0;
  logic            inputFault = 1'b0;
  logic            inputCycled = 1'b0;
  sslind_lamps_t   lamps;
  sslind_display_t display;
  logic [3:0]      circGreen;
  logic [3:0]      circYellow;
  logic [1:0]      safetyOutputPair;
  int              errCount = 0;
  int              checksDone = 0;

  always #12.5 mclk = ~mclk;

  sslind_top #(.NUM_CIRC(4), .FLASH_CYC(FC), .SEC_CYC(SC), .RST_MIN(10), .RST_MAX(40)) i_dut (
    .mclk, .rst_b, .resetClosed, .circActive, .timerSel, .runReq, .overrideReq,
    .muteActive, .faultPresent, .faultCode, .inputFault, .inputCycled,
    .lamps, .display, .circGreen, .circYellow, .safetyOutputPair
  );
  sslind_switch_model i_sw (.mclk, .go(swGo), .holdCyc(swHold), .resetClosed, .busy(swBusy));

  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checksDone++;
    if (got !== exp) begin
      errCount++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Closure of n cycles, then room for sync, qualifier and state to settle
  task automatic press(input logic [7:0] n);
    swHold <= n;
    swGo <= 1'b1;
    wt(1);
    swGo <= 1'b0;
    wt(n + 8);
  endtask

  // Collects which levels a flashing signal showed: 0 yellow, 1 red, 2 dash
  task automatic watch(input int sel, output logic [1:0] seen);
    logic b;
    seen = 2'b00;
    repeat (4 * FC) begin
      @(posedge mclk);
      b = (sel == 0) ? lamps.yellow : (sel == 1) ? lamps.red : (display.mode == DISP_DASH);
      seen[b] = 1'b1;
    end
  endtask

  task automatic t_power_up;
    logic [1:0] s;
    circActive <= 4'ha;
    wt(6);
    chk({lamps.red, lamps.green}, 2'h2);
    chk(safetyOutputPair, 2'h0);
    chk({circGreen, circYellow}, 8'haa);
    chk(display.mode, DISP_DASH);
    watch(0, s);
    chk(s, 2'h3);
  endtask

  task automatic t_bad_resets;
    runReq <= 1'b1;
    press(5);
    chk(safetyOutputPair, 2'h0);
    swHold <= 8'd50;
    swGo <= 1'b1;
    wt(1);
    swGo <= 1'b0;
    wt(48);
    chk(display, {DISP_NUMBER, ERR_RESET_INPUT});
    wt(12);
    chk({lamps.green, display.value}, {1'b0, ERR_RESET_INPUT});
    press(20);
    chk({display.mode, safetyOutputPair}, {DISP_DASH, 2'h0});
    // Valid closure must not act before the contact reopens
    swHold <= 8'd20;
    swGo <= 1'b1;
    wt(1);
    swGo <= 1'b0;
    wt(16);
    chk(safetyOutputPair, 2'h0);
    wt(12);
    chk({lamps, safetyOutputPair}, 5'h0b);
  endtask

  task automatic t_states;
    overrideReq <= 1'b1;
    wt(3);
    chk(lamps, 3'h6);
    overrideReq <= 1'b0;
    runReq <= 1'b0;
    wt(3);
    chk({lamps, safetyOutputPair}, 5'h14);
    runReq <= 1'b1;
    wt(3);
    chk(lamps, 3'h2);
  endtask

  task automatic t_fault;
    logic [1:0] s;
    faultCode <= 7'h26;
    faultPresent <= 1'b1;
    inputFault <= 1'b1;
    wt(3);
    chk({lamps.green, safetyOutputPair}, 3'h0);
    chk(display, {DISP_NUMBER, 7'h26});
    watch(1, s);
    chk(s, 2'h3);
    inputCycled <= 1'b1;
    wt(1);
    inputCycled <= 1'b0;
    faultPresent <= 1'b0;
    wt(4);
    chk(display.mode, DISP_NUMBER);
    inputCycled <= 1'b1;
    wt(1);
    inputCycled <= 1'b0;
    inputFault <= 1'b0;
    wt(4);
    chk({display.mode, lamps.red, safetyOutputPair}, {DISP_DASH, 3'h4});
    press(20);
    chk(safetyOutputPair, 2'h3);
  endtask

  task automatic t_timer;
    logic [6:0] st;
    logic [1:0] s;
    for (int i = 1; i < 4; i++) begin
      st = (i == 2) ? TLIM_60S_VAL : (i == 3) ? TLIM_30M_VAL : TLIM_30S_VAL;
      // Setting settles one cycle before the mute so the idle timer loads the new limit
      timerSel <= i[1:0];
      wt(1);
      muteActive <= 1'b1;
      wt(4);
      chk(display, {DISP_NUMBER, st});
      wt((i == 3) ? 60 * SC : SC);
      chk(display.value, st - 7'h1);
      muteActive <= 1'b0;
      wt(4);
      chk(display.mode, DISP_DASH);
    end
    timerSel <= TLIM_OFF;
    muteActive <= 1'b1;
    wt(3);
    watch(2, s);
    chk(s, 2'h3);
    muteActive <= 1'b0;
    timerSel <= TLIM_30S;
    wt(2);
    muteActive <= 1'b1;
    wt(30 * SC + 6);
    chk({display, safetyOutputPair}, {DISP_NUMBER, ERR_TIMER_EXP, 2'h0});
    muteActive <= 1'b0;
    wt(3);
    press(20);
    press(20);
    chk(safetyOutputPair, 2'h3);
  endtask

  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", checksDone, errCount);
    if (errCount == 0 && checksDone > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Main sequence: reset for four cycles, then each scenario in turn
  initial begin
    wt(4);
    rst_b <= 1'b1;
    t_power_up;
    t_bad_resets;
    t_states;
    t_fault;
    t_timer;
    give_verdict;
  end

  // Watchdog, well beyond the roughly 1100 cycles the scenarios need
  initial begin
    #200us;
    errCount++;
    give_verdict;
  end
endmodule // tb

// >>> verilog/sslind_pkg.sv
package sslind_pkg;

  // Clock and timing
  localparam int unsigned CLK_HZ           = 40000000;
  localparam int unsigned RESET_MIN_MS     = 250;
  localparam int unsigned RESET_MAX_MS     = 2000;
  localparam int unsigned FLASH_HALF_MS    = 250;
  localparam int unsigned SECOND_MS        = 1000;
  localparam int unsigned MINUTE_S         = 60;
  localparam int unsigned RESET_MIN_CYC    = (CLK_HZ / 1000) * RESET_MIN_MS;
  localparam int unsigned RESET_MAX_CYC    = (CLK_HZ / 1000) * RESET_MAX_MS;
  localparam int unsigned FLASH_HALF_CYC   = (CLK_HZ / 1000) * FLASH_HALF_MS;
  localparam int unsigned SECOND_CYC       = (CLK_HZ / 1000) * SECOND_MS;

  // Timer limit settings
  localparam logic [1:0] TLIM_OFF = 2'h0;
  localparam logic [1:0] TLIM_30S = 2'h1;
  localparam logic [1:0] TLIM_60S = 2'h2;
  localparam logic [1:0] TLIM_30M = 2'h3;
  localparam logic [6:0] TLIM_30S_VAL = 7'h1e;
  localparam logic [6:0] TLIM_60S_VAL = 7'h3c;
  localparam logic [6:0] TLIM_30M_VAL = 7'h1e;

  // Error codes shown on the display
  localparam logic [6:0] ERR_RESET_INPUT = 7'h20;
  localparam logic [6:0] ERR_TIMER_EXP   = 7'h32;

  // Display modes
  typedef enum logic [1:0] {
    DISP_DASH   = 2'b00,
    DISP_NUMBER = 2'b01,
    DISP_BLANK  = 2'b10
  } sslind_disp_t;

  typedef struct packed {
    logic red;
    logic green;
    logic yellow;
  } sslind_lamps_t;

  typedef struct packed {
    sslind_disp_t mode;
    logic [6:0]   value;
  } sslind_display_t;

  typedef enum logic [2:0] {
    ST_WAIT_RESET = 3'b000,
    ST_OUT_OFF    = 3'b001,
    ST_OUT_ON     = 3'b010,
    ST_OVERRIDE   = 3'b011,
    ST_LOCKOUT    = 3'b100
  } sslind_state_t;

endpackage

// >>> verilog/sslind_reset_qual.sv
`timescale 1ns/1ps
// Qualifies a reset closure by its hold time; pulses at the reopening edge.
module sslind_reset_qual
  import sslind_pkg::*;
#(
  parameter int unsigned MIN_CYC = RESET_MIN_CYC,
  parameter int unsigned MAX_CYC = RESET_MAX_CYC
) (
  input  wire logic mclk,        // System clock
  input  wire logic rst_b,       // Async reset, active low
  input  wire logic closedSync,  // Synchronised reset switch, high = closed
  output logic      validPulse,  // One cycle on a valid release
  output logic      stuckErr     // Held closed past the maximum
);

  initial begin
    if (MIN_CYC < 1 || MAX_CYC <= MIN_CYC || MAX_CYC >= 32'hffff_fff0)
      $error("sslind_reset_qual: bad hold limits");
  end

  logic [31:0] holdCnt_reg, holdCnt_next;
  logic        prevClosed_reg, prevClosed_next;
  logic        validPulse_reg, validPulse_next;
  logic        stuck_reg, stuck_next;

  // Count the closure; saturate one beyond the maximum so overlong holds stay invalid
  always_comb begin
    holdCnt_next    = holdCnt_reg;
    prevClosed_next = closedSync;
    validPulse_next = 1'b0;
    stuck_next      = stuck_reg;
    if (closedSync) begin
      if (holdCnt_reg <= MAX_CYC)
        holdCnt_next = holdCnt_reg + 32'h1;
      if (holdCnt_reg > MAX_CYC)
        stuck_next = 1'b1;
    end else begin
      holdCnt_next = 32'h0;
      stuck_next   = 1'b0;
      // Act only on reopening, and only inside the hold window
      if (prevClosed_reg && holdCnt_reg >= MIN_CYC && holdCnt_reg <= MAX_CYC)
        validPulse_next = 1'b1;
    end
  end

  // Registers
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      holdCnt_reg    <= 32'h0;
      prevClosed_reg <= 1'b0;
      validPulse_reg <= 1'b0;
      stuck_reg      <= 1'b0;
    end else begin
      holdCnt_reg    <= holdCnt_next;
      prevClosed_reg <= prevClosed_next;
      validPulse_reg <= validPulse_next;
      stuck_reg      <= stuck_next;
    end
  end

  assign validPulse = validPulse_reg;
  assign stuckErr   = stuck_reg;

endmodule // sslind_reset_qual

// >>> verilog/sslind_top.sv
`timescale 1ns/1ps
module sslind_top
  import sslind_pkg::*;
#(
  parameter int unsigned NUM_CIRC   = 4,
  parameter int unsigned FLASH_CYC  = FLASH_HALF_CYC,
  parameter int unsigned SEC_CYC    = SECOND_CYC,
  parameter int unsigned RST_MIN    = RESET_MIN_CYC,
  parameter int unsigned RST_MAX    = RESET_MAX_CYC
) (
  input  wire logic                mclk,          // 40 MHz clock
  input  wire logic                rst_b,         // Async reset, active low
  input  wire logic                resetClosed,   // Reset switch pin, high = closed
  input  wire logic [NUM_CIRC-1:0] circActive,    // Circuit active levels, from pins
  input  wire logic [1:0]          timerSel,      // Mute timer limit setting
  input  wire logic                runReq,        // Run permitted by guarding logic
  input  wire logic                overrideReq,   // Override active
  input  wire logic                muteActive,    // Mute cycle in progress
  input  wire logic                faultPresent,  // Some fault present
  input  wire logic [6:0]          faultCode,     // Code of that fault
  input  wire logic                inputFault,    // Fault came from an input
  input  wire logic                inputCycled,   // Offending input cycled, pulse
  output sslind_lamps_t            lamps,         // Status lamps
  output sslind_display_t          display,       // Diagnostic display
  output logic [NUM_CIRC-1:0]      circGreen,     // Per-circuit green
  output logic [NUM_CIRC-1:0]      circYellow,    // Per-circuit yellow
  output logic [1:0]               safetyOutputPair // Safety outputs, high = on
);

  initial begin
    if (NUM_CIRC < 1 || FLASH_CYC < 2 || SEC_CYC < 2)
      $error("sslind_top: bad parameters");
  end

  // Pin synchronisers; first stage feeds only the second
  logic                rstSync1_reg, rstSync2_reg;
  logic [NUM_CIRC-1:0] circSync1_reg, circSync2_reg;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rstSync1_reg  <= 1'b0;
      rstSync2_reg  <= 1'b0;
      circSync1_reg <= '0;
      circSync2_reg <= '0;
    end else begin
      rstSync1_reg  <= resetClosed;
      rstSync2_reg  <= rstSync1_reg;
      circSync1_reg <= circActive;
      circSync2_reg <= circSync1_reg;
    end
  end

  logic validReset, resetStuck;
  sslind_reset_qual #(
    .MIN_CYC (RST_MIN),
    .MAX_CYC (RST_MAX)
  ) u_rq (
    .mclk       (mclk),
    .rst_b      (rst_b),
    .closedSync (rstSync2_reg),
    .validPulse (validReset),
    .stuckErr   (resetStuck)
  );

  // Flash and one-second timebases
  logic [31:0] flashCnt_reg, flashCnt_next, secCnt_reg, secCnt_next;
  logic        flash_reg, flash_next, secTick;
  always_comb begin
    flashCnt_next = flashCnt_reg + 32'h1;
    flash_next    = flash_reg;
    if (flashCnt_reg >= FLASH_CYC - 1) begin
      flashCnt_next = 32'h0;
      flash_next    = ~flash_reg;
    end
    secTick     = (secCnt_reg >= SEC_CYC - 1);
    // Held at zero while the timer is idle, so the first step after mute start is a whole second
    if (secTick || !muteActive || timerSel == TLIM_OFF)
      secCnt_next = 32'h0;
    else
      secCnt_next = secCnt_reg + 32'h1;
  end

  // Mute limit timer, restarted whenever no mute is running
  logic [6:0] remain_reg, remain_next;
  logic [5:0] subSec_reg, subSec_next;
  logic       expired_reg, expired_next;
  logic [6:0] limitVal;
  always_comb begin
    case (timerSel)
      TLIM_30S: limitVal = TLIM_30S_VAL;
      TLIM_60S: limitVal = TLIM_60S_VAL;
      TLIM_30M: limitVal = TLIM_30M_VAL;
      default:  limitVal = 7'h00;
    endcase
    remain_next  = remain_reg;
    subSec_next  = subSec_reg;
    expired_next = expired_reg;
    if (!muteActive || timerSel == TLIM_OFF) begin
      remain_next = limitVal;
      subSec_next = 6'h00;
      if (!muteActive)
        expired_next = 1'b0;
    end else if (secTick && remain_reg != 7'h00) begin
      // Minute mode steps only once every sixty ticks
      if (timerSel == TLIM_30M && subSec_reg != 6'(MINUTE_S - 1)) begin
        subSec_next = subSec_reg + 6'h01;
      end else begin
        subSec_next = 6'h00;
        remain_next = remain_reg - 7'h01;
        if (remain_reg == 7'h01)
          expired_next = 1'b1;
      end
    end
  end

  // Main state; the latched code keeps the display stable once in lockout
  sslind_state_t state_reg, state_next;
  logic [6:0]    errCode_reg, errCode_next;
  logic          wasInputFault_reg, wasInputFault_next;
  logic          anyFault;
  logic [6:0]    curCode;
  always_comb begin
    anyFault = faultPresent | expired_reg | resetStuck;
    if (resetStuck)
      curCode = ERR_RESET_INPUT;
    else if (expired_reg)
      curCode = ERR_TIMER_EXP;
    else
      curCode = faultCode;
    state_next         = state_reg;
    errCode_next       = errCode_reg;
    wasInputFault_next = wasInputFault_reg;
    if (anyFault && state_reg != ST_LOCKOUT) begin
      state_next         = ST_LOCKOUT;
      errCode_next       = curCode;
      wasInputFault_next = inputFault & faultPresent;
    end else begin
      case (state_reg)
        ST_WAIT_RESET: if (validReset) state_next = ST_OUT_OFF;
        ST_OUT_OFF, ST_OUT_ON, ST_OVERRIDE: begin
          if (overrideReq)
            state_next = ST_OVERRIDE;
          else if (runReq)
            state_next = ST_OUT_ON;
          else
            state_next = ST_OUT_OFF;
        end
        ST_LOCKOUT: begin
          // Fault must be gone first, then cycle or reset clears it
          if (!anyFault && (validReset || (wasInputFault_reg && inputCycled)))
            state_next = ST_WAIT_RESET;
        end
        default: state_next = ST_WAIT_RESET;
      endcase
    end
  end

  // Output decode, registered so every pin comes from a flip-flop
  sslind_lamps_t   lamps_next;
  sslind_display_t disp_next;
  logic [1:0]      outs_next;
  always_comb begin
    lamps_next = '{red: 1'b1, green: 1'b0, yellow: 1'b0};
    outs_next  = 2'b00;
    disp_next  = '{mode: DISP_DASH, value: 7'h00};
    case (state_next)
      ST_WAIT_RESET: lamps_next = '{red: 1'b1, green: 1'b0, yellow: flash_next};
      ST_OUT_OFF:    lamps_next = '{red: 1'b1, green: 1'b0, yellow: 1'b1};
      ST_OUT_ON: begin
        lamps_next = '{red: 1'b0, green: 1'b1, yellow: 1'b0};
        outs_next  = 2'b11;
      end
      ST_OVERRIDE: begin
        lamps_next = '{red: 1'b1, green: 1'b1, yellow: 1'b0};
        outs_next  = 2'b11;
      end
      ST_LOCKOUT: begin
        lamps_next = '{red: flash_next, green: 1'b0, yellow: 1'b0};
        outs_next  = 2'b00;
        disp_next  = '{mode: DISP_NUMBER, value: errCode_next};
      end
      default: lamps_next = '{red: 1'b1, green: 1'b0, yellow: 1'b0};
    endcase
    if (state_next != ST_LOCKOUT) begin
      if (muteActive && timerSel != TLIM_OFF)
        disp_next = '{mode: DISP_NUMBER, value: remain_next};
      else if (muteActive && !flash_next)
        disp_next = '{mode: DISP_BLANK, value: 7'h00};
      else
        disp_next = '{mode: DISP_DASH, value: 7'h00};
    end
  end

  // Registers
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      flashCnt_reg      <= 32'h0;
      flash_reg         <= 1'b0;
      secCnt_reg        <= 32'h0;
      remain_reg        <= 7'h00;
      subSec_reg        <= 6'h00;
      expired_reg       <= 1'b0;
      state_reg         <= ST_WAIT_RESET;
      errCode_reg       <= 7'h00;
      wasInputFault_reg <= 1'b0;
      lamps             <= '{red: 1'b1, green: 1'b0, yellow: 1'b0};
      display           <= '{mode: DISP_DASH, value: 7'h00};
      safetyOutputPair  <= 2'b00;
      circGreen         <= '0;
      circYellow        <= '0;
    end else begin
      flashCnt_reg      <= flashCnt_next;
      flash_reg         <= flash_next;
      secCnt_reg        <= secCnt_next;
      remain_reg        <= remain_next;
      subSec_reg        <= subSec_next;
      expired_reg       <= expired_next;
      state_reg         <= state_next;
      errCode_reg       <= errCode_next;
      wasInputFault_reg <= wasInputFault_next;
      lamps             <= lamps_next;
      display           <= disp_next;
      safetyOutputPair  <= outs_next;
      circGreen         <= circSync2_reg;
      circYellow        <= circSync2_reg;
    end
  end

endmodule // sslind_top
